// [swc_core_model.sv]
// Model of the instruction sequencer beside the sleep and wake-up controller.
// Assumes the bench asks for a sleep with go_sleep; clk keeps running in sleep.
`timescale 1ns/10ps
`default_nettype none
module swc_core_model (
  input  wire logic clk,          // System clock
  input  wire logic resetn,       // Async reset, active low
  input  wire logic go_sleep,     // Bench asks for a sleep, pulse
  input  wire logic with_clr,     // Precede sleep by clear-watchdog
  input  wire logic slow,         // Slow finish of the wake instruction
  input  wire logic core_asleep,  // Controller sleep level
  output logic      clrwdt_exec,  // Clear-watchdog instruction pulse
  output logic      sleep_exec,   // Sleep instruction pulse
  output logic      instr_done    // Instruction finished pulse
);
  logic       asleep_d_ff;
  logic [2:0] wait_ff;

  // ****************************************************************
  // Instruction issue
  // ****************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clrwdt_exec <= 1'b0;
      sleep_exec  <= 1'b0;
    end else begin
      clrwdt_exec <= go_sleep & with_clr;
      sleep_exec  <= (go_sleep & ~with_clr) | clrwdt_exec;
    end
  end

  // ****************************************************************
  // Wake instruction
  // ****************************************************************
  // Slow mode keeps the next instruction busy for a few cycles
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      asleep_d_ff <= 1'b0;
      wait_ff     <= 3'h0;
      instr_done  <= 1'b0;
    end else begin
      asleep_d_ff <= core_asleep;
      if (asleep_d_ff && !core_asleep) begin
        wait_ff <= slow ? 3'h4 : 3'h1;
      end else if (wait_ff != 3'h0) begin
        wait_ff <= wait_ff - 3'h1;
      end
      instr_done <= (wait_ff == 3'h1);
    end
  end
endmodule
`default_nettype wire

// [swc_pin_sync.sv]
// Pin-change detector for the port pins that may wake the core.
// Assumes pins are asynchronous to clk; three flops, change taken once stages 2 and 3 agree.
`timescale 1ns/10ps
`default_nettype none
module swc_pin_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,      // System clock
  input  wire logic         resetn,   // Async reset, active low
  input  wire logic [W-1:0] pin_in,   // Raw pin levels
  output logic      [W-1:0] change    // One-cycle pulse per changed pin
);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] level_ff;
  logic [W-1:0] change_ff;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Level only moves when the two late stages agree, so a glitch is filtered
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      level_ff  <= '0;
      change_ff <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_ff[i] == s3_ff[i]) begin
          level_ff[i] <= s3_ff[i];
        end
        change_ff[i] <= (s2_ff[i] == s3_ff[i]) && (s3_ff[i] != level_ff[i]);
      end
    end
  end

  assign change = change_ff;

endmodule
`default_nettype wire

// [swc_pkg.sv]
// Constants, register map and state encoding of the sleep and wake-up controller.
// Assumes an 8-bit register port with a 4-bit word index and one 250 MHz clock.
package swc_pkg;

  // ****************************************************************
  // Register map (word index)
  // ****************************************************************
  localparam int         SWC_ADDR_W      = 4;
  localparam int         SWC_DATA_W      = 8;
  localparam logic [3:0] SWC_PIN_EN_IDX  = 4'h0;
  localparam logic [3:0] SWC_CORE_IRQ_IDX = 4'h1;
  localparam logic [3:0] SWC_PIE_A_IDX   = 4'h2;
  localparam logic [3:0] SWC_PIE_B_IDX   = 4'h3;
  localparam logic [3:0] SWC_PIR_A_IDX   = 4'h4;
  localparam logic [3:0] SWC_PIR_B_IDX   = 4'h5;
  localparam logic [3:0] SWC_SLP_STAT_IDX = 4'h6;
  localparam logic [3:0] SWC_EV_STAT_IDX = 4'h7;
  localparam logic [3:0] SWC_EV_MASK_IDX = 4'h8;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] SWC_REG_RST     = 8'h00;
  localparam logic       SWC_EXPIRY_RST  = 1'b1;
  localparam logic       SWC_ENTERED_RST = 1'b1;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int SWC_GIE_BIT   = 7;
  localparam int SWC_PERIPHERAL_IRQ_GATE_BIT  = 6;
  localparam int SWC_T0IE_BIT  = 5;
  localparam int SWC_INTE_BIT  = 4;
  localparam int SWC_PCIE_BIT  = 3;
  localparam int SWC_T0IF_BIT  = 2;
  localparam int SWC_INTF_BIT  = 1;
  localparam int SWC_PCIF_BIT  = 0;
  localparam int SWC_SSP_BIT   = 3;
  localparam int SWC_PIE_B_W   = 1;
  localparam int SWC_EXP_POS   = 1;
  localparam int SWC_ENT_POS   = 0;
  localparam int SWC_ASLP_POS  = 2;
  localparam int SWC_EV_W      = 3;
  localparam int SWC_EV_NOP    = 0;
  localparam int SWC_EV_SLEEP  = 1;
  localparam int SWC_EV_WAKE   = 2;

  // ****************************************************************
  // Core interface
  // ****************************************************************
  localparam int          SWC_PC_W     = 13;
  localparam logic [12:0] SWC_IRQ_VEC  = 13'h0004;

  typedef enum logic [1:0] {
    SWC_RUN   = 2'b00,
    SWC_SLEEP = 2'b01,
    SWC_WAKE  = 2'b10
  } swc_state_t;

endpackage

// [swc_sleep_ctrl.sv]
// Sleep entry, wake-up and power-down flag control beside the instruction sequencer.
// Assumes the core gives one-cycle instruction pulses and that clk keeps running in sleep.
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/10ps
`default_nettype none
module swc_sleep_ctrl
  import swc_pkg::*;
(
  input  wire logic                  clk,              // System clock, 250 MHz
  input  wire logic                  resetn,           // Async reset, active low
  input  wire logic [SWC_ADDR_W-1:0] reg_addr,         // Register word index
  input  wire logic [SWC_DATA_W-1:0] reg_wdata,        // Write data
  input  wire logic                  reg_wr,           // Write strobe
  input  wire logic                  reg_rd,           // Read strobe
  output logic      [SWC_DATA_W-1:0] reg_rdata,        // Read data, cycle after strobe
  input  wire logic                  sleep_exec,       // Sleep instruction executes
  input  wire logic                  clrwdt_exec,      // Clear-watchdog instruction executes
  input  wire logic                  instr_done,       // Core finished one instruction
  input  wire logic                  wdt_expire,       // Watchdog time-out pulse
  input  wire logic [7:0]            periph_evt_a,     // Peripheral events, group a
  input  wire logic                  periph_evt_b,     // Peripheral event, group b
  input  wire logic                  timer0_ovf,       // Timer 0 overflow pulse
  input  wire logic                  ext_int_evt,      // External interrupt edge pulse
  input  wire logic                  serial_addr_match, // Serial port address match
  input  wire logic                  serial_byte_done, // Serial port byte complete
  input  wire logic [7:0]            port_pins,        // Asynchronous port pins
  output logic                       core_asleep,      // Core clock gated, level
  output logic                       sleep_nop,        // Sleep finished as no-op, pulse
  output logic                       wdt_clear,        // Clear watchdog and scalers, pulse
  output logic                       vector_load,      // Load PC with vector, pulse
  output logic      [SWC_PC_W-1:0]   vector_addr,      // Vector address
  output logic                       irq_core,         // Interrupt request to core, level
  output logic                       irq_out           // Controller event interrupt, level
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [7:0]            pin_en_ff;
  logic [7:0]            core_irq_ff;
  logic [7:0]            pie_a_ff;
  logic [SWC_PIE_B_W-1:0] pie_b_ff;
  logic [7:0]            pir_a_ff;
  logic [SWC_PIE_B_W-1:0] pir_b_ff;
  logic                  expiry_flag_ff;
  logic                  entered_flag_ff;
  logic [SWC_EV_W-1:0]   ev_stat_ff;
  logic [SWC_EV_W-1:0]   ev_mask_ff;
  logic [SWC_DATA_W-1:0] rdata_ff;
  swc_state_t            state_ff;
  swc_state_t            nxt_state;
  logic                  wake_vec_ff;
  logic                  nop_ff;
  logic                  wdt_clr_ff;
  logic                  vec_load_ff;
  logic [SWC_PC_W-1:0]   vec_addr_ff;
  logic                  asleep_ff;
  logic                  irq_core_ff;
  logic                  irq_out_ff;
  logic [7:0]            pin_change;
  logic                  wake_pend;
  logic                  periph_pend;
  logic                  core_pend;
  logic                  enter_sleep;
  logic                  nop_sleep;
  logic [SWC_EV_W-1:0]   ev_set;

  // Stored value after a write, with hardware sets winning over the write
  function automatic logic [7:0] swc_merge(input logic [7:0] cur, input logic hit,
                                           input logic [7:0] wdata, input logic [7:0] set);
    swc_merge = (hit ? wdata : cur) | set;
  endfunction

  function automatic logic swc_hit(input logic wr, input logic [SWC_ADDR_W-1:0] addr,
                                   input logic [SWC_ADDR_W-1:0] idx);
    swc_hit = wr && (addr == idx);
  endfunction

  swc_pin_sync #(
    .W (8)
  ) u_pin_sync (
    .clk    (clk),
    .resetn (resetn),
    .pin_in (port_pins),
    .change (pin_change)
  );

  // ****************************************************************
  // Wake request
  // ****************************************************************
  // Global enable is not part of this term; it only decides vectoring
  assign periph_pend = (|(pie_a_ff & pir_a_ff)) || (|(pie_b_ff & pir_b_ff));
  assign core_pend   = (core_irq_ff[SWC_T0IE_BIT] && core_irq_ff[SWC_T0IF_BIT])
                    || (core_irq_ff[SWC_INTE_BIT] && core_irq_ff[SWC_INTF_BIT])
                    || (core_irq_ff[SWC_PCIE_BIT] && core_irq_ff[SWC_PCIF_BIT]);
  assign wake_pend   = periph_pend || core_pend;

  assign enter_sleep = (state_ff == SWC_RUN) && sleep_exec && !wake_pend;
  assign nop_sleep   = (state_ff == SWC_RUN) && sleep_exec && wake_pend;

  // ****************************************************************
  // Sleep sequencer
  // ****************************************************************
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      SWC_RUN: begin
        if (enter_sleep) begin
          nxt_state = SWC_SLEEP;
        end
      end
      SWC_SLEEP: begin
        if (wake_pend || wdt_expire) begin
          nxt_state = SWC_WAKE;
        end
      end
      SWC_WAKE: begin
        if (instr_done) begin
          nxt_state = SWC_RUN;
        end
      end
      default: begin
        nxt_state = SWC_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff  <= SWC_RUN;
      asleep_ff <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      asleep_ff <= (nxt_state == SWC_SLEEP);
    end
  end

  // Vector decision taken at wake time, used after the next instruction
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wake_vec_ff <= 1'b0;
    end else if (state_ff == SWC_SLEEP) begin
      wake_vec_ff <= wake_pend && core_irq_ff[SWC_GIE_BIT];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      vec_load_ff <= 1'b0;
      vec_addr_ff <= '0;
    end else begin
      vec_load_ff <= (state_ff == SWC_WAKE) && instr_done && wake_vec_ff;
      vec_addr_ff <= SWC_IRQ_VEC;
    end
  end

  // Clear on real entry or clear-watchdog; a no-op sleep leaves the watchdog running
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wdt_clr_ff <= 1'b0;
      nop_ff     <= 1'b0;
    end else begin
      wdt_clr_ff <= enter_sleep || clrwdt_exec;
      nop_ff     <= nop_sleep;
    end
  end

  // ****************************************************************
  // Power-down and expiry flags
  // ****************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      expiry_flag_ff  <= SWC_EXPIRY_RST;
      entered_flag_ff <= SWC_ENTERED_RST;
    end else if (wdt_expire) begin
      expiry_flag_ff  <= 1'b0;
    end else if (enter_sleep) begin
      expiry_flag_ff  <= 1'b1;
      entered_flag_ff <= 1'b0;
    end else if (clrwdt_exec) begin
      expiry_flag_ff  <= 1'b1;
      entered_flag_ff <= 1'b1;
    end
  end

  // ****************************************************************
  // Interrupt enable and flag registers
  // ****************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_en_ff <= SWC_REG_RST;
      pie_a_ff  <= SWC_REG_RST;
      pie_b_ff  <= '0;
    end else begin
      pin_en_ff <= swc_merge(pin_en_ff, swc_hit(reg_wr, reg_addr, SWC_PIN_EN_IDX),
                             reg_wdata, 8'h00);
      pie_a_ff  <= swc_merge(pie_a_ff, swc_hit(reg_wr, reg_addr, SWC_PIE_A_IDX),
                             reg_wdata, 8'h00);
      if (swc_hit(reg_wr, reg_addr, SWC_PIE_B_IDX)) begin
        pie_b_ff <= reg_wdata[SWC_PIE_B_W-1:0];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      core_irq_ff <= SWC_REG_RST;
    end else begin
      core_irq_ff <= swc_merge(core_irq_ff, swc_hit(reg_wr, reg_addr, SWC_CORE_IRQ_IDX),
                               reg_wdata,
                               {5'h00, timer0_ovf, ext_int_evt,
                                |(pin_change & pin_en_ff)});
    end
  end

  // Serial port keeps receiving in sleep; its flag wakes only via its enable
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pir_a_ff <= SWC_REG_RST;
      pir_b_ff <= '0;
    end else begin
      pir_a_ff <= swc_merge(pir_a_ff, swc_hit(reg_wr, reg_addr, SWC_PIR_A_IDX), reg_wdata,
                            periph_evt_a
                            | ({7'h00, serial_addr_match || serial_byte_done}
                               << SWC_SSP_BIT));
      if (swc_hit(reg_wr, reg_addr, SWC_PIR_B_IDX)) begin
        pir_b_ff <= reg_wdata[SWC_PIE_B_W-1:0] | periph_evt_b;
      end else begin
        pir_b_ff <= pir_b_ff | periph_evt_b;
      end
    end
  end

  // ****************************************************************
  // Controller events and interrupt outputs
  // ****************************************************************
  assign ev_set = {(state_ff == SWC_SLEEP) && (nxt_state == SWC_WAKE), enter_sleep, nop_sleep};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ev_stat_ff <= '0;
      ev_mask_ff <= '0;
    end else begin
      if (swc_hit(reg_wr, reg_addr, SWC_EV_STAT_IDX)) begin
        ev_stat_ff <= (ev_stat_ff & ~reg_wdata[SWC_EV_W-1:0]) | ev_set;
      end else begin
        ev_stat_ff <= ev_stat_ff | ev_set;
      end
      if (swc_hit(reg_wr, reg_addr, SWC_EV_MASK_IDX)) begin
        ev_mask_ff <= reg_wdata[SWC_EV_W-1:0];
      end
    end
  end

  // Vectoring in run needs global enable, peripherals also need their gate
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_core_ff <= 1'b0;
      irq_out_ff  <= 1'b0;
    end else begin
      irq_core_ff <= (state_ff == SWC_RUN) && core_irq_ff[SWC_GIE_BIT]
                  && (core_pend || (periph_pend && core_irq_ff[SWC_PERIPHERAL_IRQ_GATE_BIT]));
      irq_out_ff  <= |(ev_stat_ff & ev_mask_ff);
    end
  end

  // ****************************************************************
  // Register read port
  // ****************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_ff <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        SWC_PIN_EN_IDX:   rdata_ff <= pin_en_ff;
        SWC_CORE_IRQ_IDX: rdata_ff <= core_irq_ff;
        SWC_PIE_A_IDX:    rdata_ff <= pie_a_ff;
        SWC_PIE_B_IDX:    rdata_ff <= {7'h00, pie_b_ff};
        SWC_PIR_A_IDX:    rdata_ff <= pir_a_ff;
        SWC_PIR_B_IDX:    rdata_ff <= {7'h00, pir_b_ff};
        SWC_SLP_STAT_IDX: rdata_ff <= {5'h00, asleep_ff, expiry_flag_ff, entered_flag_ff};
        SWC_EV_STAT_IDX:  rdata_ff <= {5'h00, ev_stat_ff};
        SWC_EV_MASK_IDX:  rdata_ff <= {5'h00, ev_mask_ff};
        default:          rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  assign reg_rdata   = rdata_ff;
  assign core_asleep = asleep_ff;
  assign sleep_nop   = nop_ff;
  assign wdt_clear   = wdt_clr_ff;
  assign vector_load = vec_load_ff;
  assign vector_addr = vec_addr_ff;
  assign irq_core    = irq_core_ff;
  assign irq_out     = irq_out_ff;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  masked_sleep_a: assert property (
    (state_ff == SWC_RUN) && sleep_exec && wake_pend && !core_irq_ff[SWC_GIE_BIT]
    |=> !core_asleep && sleep_nop)
    else $error("pending source with global enable off did not block sleep");

  nop_sleep_a: assert property (
    nop_sleep |=> !wdt_clear && (expiry_flag_ff == $past(expiry_flag_ff))
                  && (state_ff == SWC_RUN))
    else $error("no-op sleep touched watchdog or flags");

  fast_wake_a: assert property (
    (state_ff == SWC_SLEEP) && wake_pend |=> (state_ff == SWC_WAKE) && !core_asleep)
    else $error("enabled flag did not wake at once");

  entry_flags_a: assert property (
    enter_sleep && !wdt_expire |=> wdt_clear && expiry_flag_ff && !entered_flag_ff
                                   && core_asleep)
    else $error("sleep entry did not clear watchdog or set flags");

  pd_kept_a: assert property (
    nop_sleep && !clrwdt_exec |=> $stable(entered_flag_ff) && !core_asleep)
    else $error("sleep flag changed after no-op sleep");

  clrwdt_a: assert property (
    clrwdt_exec && !wdt_expire && !enter_sleep |=> wdt_clear && expiry_flag_ff
                                                   && entered_flag_ff)
    else $error("clear-watchdog did not clear and set flags");

  serial_wake_a: assert property (
    (state_ff == SWC_SLEEP) && serial_byte_done && pie_a_ff[SWC_SSP_BIT]
    |-> ##[1:2] (state_ff == SWC_WAKE))
    else $error("serial byte did not wake the core");

  vector_a: assert property (
    (state_ff == SWC_WAKE) && instr_done && wake_vec_ff
    |=> vector_load && (vector_addr == SWC_IRQ_VEC) && (state_ff == SWC_RUN))
    else $error("vector not loaded after wake instruction");

  pin_flag_a: assert property (
    |(pin_change & pin_en_ff) |=> core_irq_ff[SWC_PCIF_BIT])
    else $error("enabled pin change did not set its flag");

  irq_level_a: assert property (
    |(ev_stat_ff & ev_mask_ff) |=> irq_out)
    else $error("unmasked event did not raise interrupt");

endmodule
`default_nettype wire

// [tb.sv]
// Self-checking bench of the sleep and wake-up controller.
// Assumes the core model above drives the instruction pulses.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin fail_count++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module tb;
  import swc_pkg::*;
  logic clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, wdt_expire = 0, ev_b = 0, t0 = 0;
  logic ext = 0, s_match = 0, s_done = 0, go_sleep = 0, with_clr = 0, slow = 0;
  logic [3:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0, reg_rdata, ev_a = '0, port_pins = '0, d;
  logic core_asleep, sleep_nop, wdt_clear, vector_load, irq_core, irq_out;
  logic clrwdt_exec, sleep_exec, instr_done;
  logic [12:0] vector_addr;
  int fail_count = 0, comparisons = 0, nop_cnt = 0, clr_cnt = 0, vec_cnt = 0;
  bit ok;

  always #2 clk = ~clk;

  swc_sleep_ctrl dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_exec(sleep_exec),
    .clrwdt_exec(clrwdt_exec), .instr_done(instr_done), .wdt_expire(wdt_expire),
    .periph_evt_a(ev_a), .periph_evt_b(ev_b), .timer0_ovf(t0), .ext_int_evt(ext),
    .serial_addr_match(s_match), .serial_byte_done(s_done), .port_pins(port_pins),
    .core_asleep(core_asleep), .sleep_nop(sleep_nop), .wdt_clear(wdt_clear),
    .vector_load(vector_load), .vector_addr(vector_addr), .irq_core(irq_core),
    .irq_out(irq_out));

  swc_core_model core (.clk(clk), .resetn(resetn), .go_sleep(go_sleep), .with_clr(with_clr),
    .slow(slow), .core_asleep(core_asleep), .clrwdt_exec(clrwdt_exec),
    .sleep_exec(sleep_exec), .instr_done(instr_done));

  // Pulse outputs are counted so checks need not hit the exact cycle
  always @(posedge clk) begin
    nop_cnt <= nop_cnt + sleep_nop;
    clr_cnt <= clr_cnt + wdt_clear;
    vec_cnt <= vec_cnt + vector_load;
  end

  // ****************************************************************
  // Access tasks
  // ****************************************************************
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic do_sleep(input logic clr, input logic slw);
    @(posedge clk);
    go_sleep <= 1'b1;
    with_clr <= clr;
    slow <= slw;
    @(posedge clk);
    go_sleep <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
  endtask

  task automatic wait_wake();
    ok = 0;
    for (int i = 0; i < 20 && !ok; i++) begin
      @(posedge clk);
      #1;
      if (core_asleep === 1'b0) ok = 1;
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Run takes well under 2000 cycles
  initial begin
    #40000;
    fail_count++;
    end_sim();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    repeat (5) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      rd(i[3:0]);
      `CHK("reset value", (i == 6) ? 8'h03 : 8'h00, d)
    end
    // No-op sleep: serial source pending, global enable off
    @(posedge clk) wdt_expire <= 1'b1;
    @(posedge clk) wdt_expire <= 1'b0;
    wr(SWC_PIE_A_IDX, 8'h08);
    @(posedge clk) s_done <= 1'b1;
    @(posedge clk) s_done <= 1'b0;
    do_sleep(1'b0, 1'b0);
    `CHK("nop pulses", 1, nop_cnt)
    `CHK("no wdt clear", 0, clr_cnt)
    `CHK("stays awake", 1'b0, core_asleep)
    rd(SWC_SLP_STAT_IDX);
    `CHK("flags after nop", 8'h01, d)
    // Real sleep, serial source disabled, then enabled late
    wr(SWC_PIR_A_IDX, 8'h00);
    wr(SWC_PIE_A_IDX, 8'h00);
    wr(SWC_CORE_IRQ_IDX, 8'hC0);
    do_sleep(1'b1, 1'b1);
    `CHK("asleep", 1'b1, core_asleep)
    `CHK("wdt clears", 2, clr_cnt)
    rd(SWC_SLP_STAT_IDX);
    `CHK("flags in sleep", 8'h06, d)
    @(posedge clk) s_match <= 1'b1;
    @(posedge clk) s_match <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    `CHK("serial gated", 1'b1, core_asleep)
    wr(SWC_PIR_A_IDX, 8'h00);
    wr(SWC_PIE_A_IDX, 8'h08);
    #1;
    `CHK("still asleep", 1'b1, core_asleep)
    @(posedge clk) s_done <= 1'b1;
    @(posedge clk) s_done <= 1'b0;
    wait_wake();
    `CHK("serial wake", 1'b1, ok)
    repeat (10) @(posedge clk);
    #1;
    `CHK("vector loads", 1, vec_cnt)
    `CHK("vector addr", SWC_IRQ_VEC, vector_addr)
    `CHK("irq to core", 1'b1, irq_core)
    // Pin-change wake, only the enabled pin counts
    wr(SWC_PIR_A_IDX, 8'h00);
    wr(SWC_CORE_IRQ_IDX, 8'h08);
    wr(SWC_PIN_EN_IDX, 8'h80);
    do_sleep(1'b0, 1'b0);
    `CHK("asleep again", 1'b1, core_asleep)
    @(posedge clk) port_pins <= 8'h01;
    repeat (10) @(posedge clk);
    #1;
    `CHK("masked pin", 1'b1, core_asleep)
    @(posedge clk) port_pins <= 8'h81;
    wait_wake();
    `CHK("pin wake", 1'b1, ok)
    repeat (8) @(posedge clk);
    #1;
    `CHK("no vector", 1, vec_cnt)
    // Timer and group-b sources also turn sleep into a no-op
    wr(SWC_CORE_IRQ_IDX, 8'h20);
    @(posedge clk) t0 <= 1'b1;
    @(posedge clk) t0 <= 1'b0;
    rd(SWC_CORE_IRQ_IDX);
    `CHK("timer flag", 8'h24, d)
    do_sleep(1'b0, 1'b0);
    `CHK("timer nop", 2, nop_cnt)
    wr(SWC_CORE_IRQ_IDX, 8'h00);
    wr(SWC_PIE_B_IDX, 8'h01);
    @(posedge clk) ev_b <= 1'b1;
    @(posedge clk) ev_b <= 1'b0;
    rd(SWC_PIR_B_IDX);
    `CHK("group b flag", 8'h01, d)
    do_sleep(1'b0, 1'b0);
    `CHK("group b nop", 3, nop_cnt)
    `CHK("nop keeps wdt", 3, clr_cnt)
    // Event interrupt: raise, mask, clear
    rd(SWC_EV_STAT_IDX);
    `CHK("event status", 8'h07, d)
    wr(SWC_EV_MASK_IDX, 8'h02);
    repeat (2) @(posedge clk);
    #1;
    `CHK("irq raised", 1'b1, irq_out)
    wr(SWC_EV_STAT_IDX, 8'h02);
    repeat (2) @(posedge clk);
    #1;
    `CHK("irq cleared", 1'b0, irq_out)
    rd(SWC_EV_STAT_IDX);
    `CHK("status after clear", 8'h05, d)
    end_sim();
  end
endmodule
`default_nettype wire
